// file: logic/lfd_mst.sv
`include "lfd_regs.svh"
`default_nettype none
module lfd_mst (
  // Link side.
  lfd_if.master          bus,
  // Command side.
  input  wire logic      core_clk_i,
  input  wire logic      srst_i,
  input  wire logic      cmd_valid_i,
  input  wire logic      cmd_start_i,
  input  wire logic      cmd_stop_i,
  input  wire logic      cmd_read_i,
  input  wire logic      cmd_nack_i,
  input  wire logic [7:0] cmd_data_i,
  output logic           cmd_ready_o,
  output var  logic      done_o,
  output var  logic [7:0] rx_data_o,
  output var  logic      rx_ack_o
);
  import lfd_pkg::*;

  typedef struct packed {
    lfd_mst_state_t st;
    logic [7:0]     div;
    logic [1:0]     ph;
    logic [2:0]     bitn;
    logic [7:0]     sh;
    logic           rd;
    logic           nack;
    logic           stop;
    logic           scl;
    logic           sda;
    logic           done;
    logic [7:0]     rx;
    logic           ack;
    logic [1:0]     sda_s;
  } lfd_mst_t;

  lfd_mst_t q_ff, nxt_q;
  logic     tick;
  assign tick        = q_ff.div == `LFD_CLK_DIV;
  assign cmd_ready_o = q_ff.st == LFD_M_IDLE || q_ff.st == LFD_M_HOLD;

  always_comb begin
    nxt_q       = q_ff;
    nxt_q.done  = 1'b0;
    nxt_q.sda_s = {q_ff.sda_s[0], bus.sda};
    nxt_q.div   = tick ? 8'h00 : q_ff.div + 8'h01;
    case (q_ff.st)
      LFD_M_IDLE, LFD_M_HOLD: begin
        if (cmd_valid_i) begin
          nxt_q.sh   = cmd_data_i;
          nxt_q.rd   = cmd_read_i;
          nxt_q.nack = cmd_nack_i;
          nxt_q.stop = cmd_stop_i;
          nxt_q.ph   = 2'h0;
          nxt_q.bitn = 3'h7;
          nxt_q.div  = 8'h00;
          if (cmd_start_i) begin
            nxt_q.st = q_ff.st == LFD_M_IDLE ? LFD_M_START : LFD_M_RSTRT;
          end else begin
            nxt_q.st = LFD_M_BIT;
          end
        end
      end
      LFD_M_RSTRT: if (tick) begin
        nxt_q.ph = q_ff.ph + 2'h1;
        case (q_ff.ph)
          2'h0: nxt_q.sda = 1'b1;
          2'h1: nxt_q.scl = 1'b1;
          default: begin
            nxt_q.st = LFD_M_START;
            nxt_q.ph = 2'h0;
          end
        endcase
      end
      LFD_M_START: if (tick) begin
        nxt_q.ph = q_ff.ph + 2'h1;
        if (q_ff.ph == 2'h0) begin
          nxt_q.sda = 1'b0;
        end else begin
          nxt_q.scl = 1'b0;
          nxt_q.st  = LFD_M_BIT;
          nxt_q.ph  = 2'h0;
        end
      end
      LFD_M_BIT, LFD_M_ACK: if (tick) begin
        nxt_q.ph = q_ff.ph + 2'h1;
        case (q_ff.ph)
          2'h0: begin
            if (q_ff.st == LFD_M_BIT) begin
              nxt_q.sda = q_ff.rd | q_ff.sh[7];
            end else begin
              nxt_q.sda = ~q_ff.rd | q_ff.nack;
            end
          end
          2'h1: nxt_q.scl = 1'b1;
          2'h2: begin
            if (q_ff.st == LFD_M_BIT) begin
              nxt_q.sh = {q_ff.sh[6:0], q_ff.sda_s[1]};
            end else begin
              nxt_q.ack = ~q_ff.sda_s[1];
            end
          end
          default: begin
            nxt_q.scl = 1'b0;
            if (q_ff.st == LFD_M_ACK) begin
              nxt_q.rx = q_ff.sh;
              nxt_q.st = q_ff.stop ? LFD_M_STOP : LFD_M_DONE;
            end else if (q_ff.bitn == 3'h0) begin
              nxt_q.st = LFD_M_ACK;
            end else begin
              nxt_q.bitn = q_ff.bitn - 3'h1;
            end
          end
        endcase
      end
      LFD_M_STOP: if (tick) begin
        nxt_q.ph = q_ff.ph + 2'h1;
        case (q_ff.ph)
          2'h0: nxt_q.sda = 1'b0;
          2'h1: nxt_q.scl = 1'b1;
          default: begin
            nxt_q.sda  = 1'b1;
            nxt_q.done = 1'b1;
            nxt_q.st   = LFD_M_IDLE;
          end
        endcase
      end
      LFD_M_DONE: begin
        nxt_q.done = 1'b1;
        nxt_q.st   = LFD_M_HOLD;
      end
      default: nxt_q.st = LFD_M_IDLE;
    endcase
    if (srst_i) begin
      nxt_q     = '0;
      nxt_q.st  = LFD_M_IDLE;
      nxt_q.scl = 1'b1;
      nxt_q.sda = 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    q_ff <= nxt_q;
  end

  assign bus.scl_o    = 1'b0;
  assign bus.scl_oe   = ~q_ff.scl;
  assign bus.sda_m_o  = 1'b0;
  assign bus.sda_m_oe = ~q_ff.sda;
  assign done_o       = q_ff.done;
  assign rx_data_o    = q_ff.rx;
  assign rx_ack_o     = q_ff.ack;
endmodule
`default_nettype wire

// file: shared/lfd_regs.svh
`ifndef LFD_REGS_SVH
`define LFD_REGS_SVH
`define LFD_SLAVE_ADDR  7'h30
`define LFD_PTR_RST     8'h00
`define LFD_CLK_DIV     8'h0C
`define LFD_BIT_CNT_RST 4'h0
`endif

// file: shared/lfd_pkg.sv
`default_nettype none
package lfd_pkg;
  typedef enum logic [5:0] {
    LFD_S_IDLE = 6'h01,
    LFD_S_ADDR = 6'h02,
    LFD_S_PTR  = 6'h04,
    LFD_S_WDAT = 6'h08,
    LFD_S_RDAT = 6'h10,
    LFD_S_SKIP = 6'h20
  } lfd_dev_state_t;

  typedef enum logic [7:0] {
    LFD_M_IDLE  = 8'h01,
    LFD_M_START = 8'h02,
    LFD_M_BIT   = 8'h04,
    LFD_M_ACK   = 8'h08,
    LFD_M_STOP  = 8'h10,
    LFD_M_DONE  = 8'h20,
    LFD_M_RSTRT = 8'h40,
    LFD_M_HOLD  = 8'h80
  } lfd_mst_state_t;

  typedef logic [7:0] lfd_byte_t;
endpackage
`default_nettype wire

// file: shared/lfd_if.sv
`default_nettype none
interface lfd_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = scl_oe ? scl_o : 1'b1;
  assign sda = (sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o) ? 1'b0
             : 1'b1;
  modport master (output scl_o, output scl_oe, output sda_m_o,
                  output sda_m_oe, input scl, input sda);
  modport device (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface
`default_nettype wire

// file: logic/lfd_dev.sv
`include "lfd_regs.svh"
`default_nettype none
module lfd_dev (
  // Link side, clocked by the serial clock.
  lfd_if.device          bus,
  // Core side.
  input  wire logic      core_clk_i,
  input  wire logic      srst_i,
  output var  logic      wr_stb_o,
  output var  logic [7:0] wr_addr_o,
  output var  logic [7:0] wr_data_o,
  output var  logic [7:0] rd_addr_o,
  input  wire logic [7:0] rd_data_i
);
  import lfd_pkg::*;

  // ----------------------------------------------------------
  // Link domain state.
  // ----------------------------------------------------------
  typedef struct packed {
    lfd_dev_state_t st;
    logic [3:0]     bitc;
    logic [7:0]     sh;
    logic [7:0]     ptr;
    logic           rd;
    logic           drv;
    logic           wr_tgl;
    logic [7:0]     wa;
    logic [7:0]     wd;
  } lfd_dev_link_t;

  // Link state powers up idle, as the link domain has no reset.
  lfd_dev_link_t link_ff = '{st: LFD_S_IDLE, ptr: `LFD_PTR_RST,
                             default: '0};
  lfd_dev_link_t nxt_link;
  logic          start_ff = 1'b0;
  logic          stop_tgl_ff = 1'b0;
  logic          stop_seen_ff = 1'b0;
  logic          scl_neg_drv = 1'b0;
  logic          sda_val;

  assign sda_val = bus.sda;

  always_ff @(negedge sda_val) begin
    if (bus.scl) begin
      start_ff <= ~start_ff;
    end
  end

  always_ff @(posedge sda_val) begin
    if (bus.scl) begin
      stop_tgl_ff <= ~stop_tgl_ff;
    end
  end

  logic start_seen_ff = 1'b0;
  logic start_new;
  logic stop_new;
  assign start_new = start_ff != start_seen_ff;
  assign stop_new  = stop_tgl_ff != stop_seen_ff;

  always_comb begin
    nxt_link = link_ff;
    // START or STOP restarts the decoder.
    if (start_new) begin
      // The first rising edge after START carries the first address bit.
      nxt_link.st   = LFD_S_ADDR;
      nxt_link.sh   = {link_ff.sh[6:0], sda_val};
      nxt_link.bitc = 4'h1;
    end else if (stop_new) begin
      nxt_link.st   = LFD_S_IDLE;
      nxt_link.bitc = `LFD_BIT_CNT_RST;
    end else if (link_ff.st != LFD_S_IDLE && link_ff.st != LFD_S_SKIP) begin
      if (link_ff.bitc < 4'h8) begin
        nxt_link.sh   = {link_ff.sh[6:0], sda_val};
        nxt_link.bitc = link_ff.bitc + 4'h1;
      end else begin
        nxt_link.bitc = `LFD_BIT_CNT_RST;
        case (link_ff.st)
          LFD_S_ADDR: begin
            if (link_ff.sh[7:1] == `LFD_SLAVE_ADDR) begin
              nxt_link.rd = link_ff.sh[0];
              nxt_link.st = link_ff.sh[0] ? LFD_S_RDAT : LFD_S_PTR;
            end else begin
              nxt_link.st = LFD_S_SKIP;
            end
          end
          LFD_S_PTR: begin
            nxt_link.ptr = link_ff.sh;
            nxt_link.st  = LFD_S_WDAT;
          end
          LFD_S_WDAT: begin
            nxt_link.wa     = link_ff.ptr;
            nxt_link.wd     = link_ff.sh;
            nxt_link.wr_tgl = ~link_ff.wr_tgl;
            nxt_link.ptr    = link_ff.ptr + 8'h01;
          end
          LFD_S_RDAT: begin
            if (sda_val) begin
              nxt_link.st = LFD_S_SKIP;
            end
            nxt_link.ptr = link_ff.ptr + 8'h01;
          end
          default: nxt_link.st = LFD_S_SKIP;
        endcase
      end
    end
  end

  always_ff @(posedge bus.scl) begin
    link_ff       <= nxt_link;
    start_seen_ff <= start_ff;
    stop_seen_ff  <= stop_tgl_ff;
  end

  // ----------------------------------------------------------
  // Data line driver, updated while SCL is low.
  // ----------------------------------------------------------
  logic [7:0] rd_byte;
  logic       ack_slot;
  logic       ack_drv;
  logic       rd_drv;
  assign rd_byte  = rd_data_i;
  assign ack_slot = link_ff.bitc == 4'h8;
  // Acknowledge own address and written bytes.
  assign ack_drv  = ack_slot &&
                    ((link_ff.st == LFD_S_ADDR &&
                      link_ff.sh[7:1] == `LFD_SLAVE_ADDR) ||
                     link_ff.st == LFD_S_PTR || link_ff.st == LFD_S_WDAT);
  // Transmit from current pointer, MSB first.
  assign rd_drv   = link_ff.st == LFD_S_RDAT && !ack_slot &&
                    !rd_byte[3'h7 - link_ff.bitc[2:0]];

  // Output changes on the falling clock edge.
  // Low level held across the high phase.
  always_ff @(negedge bus.scl) begin
    scl_neg_drv <= (ack_drv || rd_drv) && !start_new;
  end

  assign bus.sda_s_o  = 1'b0;
  assign bus.sda_s_oe = scl_neg_drv;
  assign rd_addr_o    = link_ff.ptr;

  // ----------------------------------------------------------
  // Write event crossing into the core clock.
  // ----------------------------------------------------------
  typedef struct packed {
    logic [2:0] tgl;
    logic       stb;
    logic [7:0] wa;
    logic [7:0] wd;
  } lfd_dev_core_t;

  lfd_dev_core_t core_ff, nxt_core;

  always_comb begin
    nxt_core     = core_ff;
    nxt_core.tgl = {core_ff.tgl[1:0], link_ff.wr_tgl};
    nxt_core.stb = core_ff.tgl[2] != core_ff.tgl[1];
    if (core_ff.tgl[2] != core_ff.tgl[1]) begin
      nxt_core.wa = link_ff.wa;
      nxt_core.wd = link_ff.wd;
    end
    if (srst_i) begin
      nxt_core = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    core_ff <= nxt_core;
  end

  assign wr_stb_o  = core_ff.stb;
  assign wr_addr_o = core_ff.wa;
  assign wr_data_o = core_ff.wd;
endmodule
`default_nettype wire

// file: verification/lfd_monitor.sv
`include "lfd_regs.svh"
`default_nettype none
module lfd_monitor (
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Bus wires and enables.
  input wire logic scl,
  input wire logic sda,
  input wire logic scl_oe,
  input wire logic sda_m_oe,
  input wire logic sda_s_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_ff;
  logic [6:0] sh_ff;
  logic       fb_ff, rd_ff, skip_ff, scl_ff, sda_ff;
  wire logic  start = scl && scl_ff && sda_ff && !sda;
  wire logic  stop  = scl && scl_ff && !sda_ff && sda;
  wire logic  rise  = scl && !scl_ff;
  wire logic  ack   = rise && cnt_ff == 4'h8;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  // Tracks bit slots, the first byte and a rejected address.
  always_ff @(posedge core_clk_i) begin
    scl_ff <= scl || srst_i;
    sda_ff <= sda || srst_i;
    if (srst_i || start) begin
      cnt_ff  <= 4'h0;
      fb_ff   <= !srst_i;
      skip_ff <= 1'b0;
    end else if (rise) begin
      cnt_ff <= (cnt_ff == 4'h8) ? 4'h0 : cnt_ff + 4'h1;
      sh_ff  <= {sh_ff[5:0], sda};
      if (fb_ff && cnt_ff == 4'h7) begin
        skip_ff <= sh_ff != `LFD_SLAVE_ADDR;
        rd_ff   <= sda;
      end
      if (cnt_ff == 4'h8) begin
        fb_ff <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_rst_release: assert property (disable iff (1'b0)
    srst_i |=> !scl_oe && !sda_m_oe) else $error("lines held in reset");
  a_dev_steady: assert property (
    $changed(sda_s_oe) && !start && !stop |-> !scl)
    else $error("device moved sda while scl high");
  a_scl_pulse: assert property (rise |-> scl [*8])
    else $error("clock pulse too short");
  a_start_clock: assert property (start |-> ##[1:30] !scl)
    else $error("no clock after start");
  a_stop_idle: assert property (stop |-> (scl && sda) [*4])
    else $error("bus not idle after stop");
  a_ack_held: assert property (
    ack && !skip_ff && (fb_ff || !rd_ff) |-> !sda [*8])
    else $error("acknowledge not held low");
  a_mst_release: assert property (
    ack && (fb_ff || !rd_ff) |-> !sda_m_oe)
    else $error("master drives ack slot");
  a_skip_quiet: assert property (skip_ff |-> !sda_s_oe)
    else $error("device answers foreign address");
  a_nack_release: assert property (
    ack && rd_ff && !fb_ff && sda |=> !sda_s_oe [*8])
    else $error("device drives after not-ack");
  c_skip: cover property (skip_ff);
endmodule
`default_nettype wire

// file: verification/i2c_slave_register_port_tb_top.sv
`default_nettype none
module i2c_slave_register_port_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i;
  logic [7:0]  cmd_data_i, rx_data_o, wr_addr_o, wr_data_o, rd_addr_o;
  logic [7:0]  rd_data_i, wire_byte, wire_last, ptr, d;
  logic        cmd_ready_o, done_o, rx_ack_o, wr_stb_o;
  logic [7:0]  mem [256];
  logic [7:0]  ref_m [256];
  logic [10:0] note_q [$];
  logic [10:0] n;
  logic [15:0] wr_q [$];
  logic [31:0] lfsr = 32'h8E27;
  int          bad_count, comparisons, wcnt;
  lfd_if bus ();
  assign rd_data_i = mem[rd_addr_o];
  lfd_mst lfd_mst_inst (.bus(bus), .core_clk_i(core_clk_i), .srst_i(srst_i),
    .cmd_valid_i(cmd_valid_i), .cmd_start_i(cmd_start_i),
    .cmd_stop_i(cmd_stop_i), .cmd_read_i(cmd_read_i),
    .cmd_nack_i(cmd_nack_i), .cmd_data_i(cmd_data_i),
    .cmd_ready_o(cmd_ready_o), .done_o(done_o), .rx_data_o(rx_data_o),
    .rx_ack_o(rx_ack_o));
  lfd_dev lfd_dev_inst (.bus(bus), .core_clk_i(core_clk_i), .srst_i(srst_i),
    .wr_stb_o(wr_stb_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
    .rd_addr_o(rd_addr_o), .rd_data_i(rd_data_i));
  lfd_monitor lfd_monitor_inst (.core_clk_i(core_clk_i), .srst_i(srst_i),
    .scl(bus.scl), .sda(bus.sda), .scl_oe(bus.scl_oe),
    .sda_m_oe(bus.sda_m_oe), .sda_s_oe(bus.sda_s_oe));
  initial forever #50 core_clk_i = ~core_clk_i;
  // Captures each byte as it stands on the wire.
  always @(negedge bus.sda) if (bus.scl) wcnt = 0;
  always @(posedge bus.scl) begin
    wire_byte = (wcnt < 8) ? {wire_byte[6:0], bus.sda} : wire_byte;
    if (wcnt == 8) wire_last = wire_byte;
    wcnt = (wcnt == 8) ? 0 : wcnt + 1;
  end
  function automatic logic [7:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr[7:0];
  endfunction
  task automatic mism(input string s);
    bad_count++;
    $display("MISMATCH %0t %s", $time, s);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Flags are start, stop, read, not-ack; c is check-ack, ack, read.
  task automatic cmd(input logic [3:0] f, input logic [7:0] b,
                     input logic [2:0] c);
    note_q.push_back({c, b});
    @(posedge core_clk_i);
    #1 {cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i} = f;
    cmd_data_i  = b;
    cmd_valid_i = 1'b1;
    for (int i = 0; i < 3000 && cmd_ready_o !== 1'b1; i++)
      @(negedge core_clk_i);
    @(posedge core_clk_i);
    #1 cmd_valid_i = 1'b0;
  endtask
  always @(posedge core_clk_i) begin
    if (done_o === 1'b1 && note_q.size() == 0) mism("extra byte");
    else if (done_o === 1'b1) begin
      n = note_q.pop_front();
      comparisons += 2;
      if (wire_last !== n[7:0]) mism("wire byte");
      if (n[10] && rx_ack_o !== n[9]) mism("ack");
      if (n[8] && rx_data_o !== n[7:0]) mism("read data");
    end
    if (wr_stb_o === 1'b1) begin
      comparisons++;
      if (wr_q.size() == 0 || {wr_addr_o, wr_data_o} !== wr_q.pop_front())
        mism("register write");
      mem[wr_addr_o] <= wr_data_o;
    end
  end
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    {cmd_valid_i, cmd_start_i, cmd_stop_i, cmd_read_i, cmd_nack_i} = 5'h00;
    cmd_data_i = 8'h00;
    for (int i = 0; i < 256; i++) begin
      mem[i]   = rnd();
      ref_m[i] = mem[i];
    end
    repeat (6) @(posedge core_clk_i);
    #1 srst_i = 1'b0;
    for (int t = 0; t < 3; t++) begin
      ptr = rnd();
      cmd(4'h8, 8'h60, 3'h6);
      cmd(4'h0, ptr, 3'h6);
      for (int k = 0; k < t; k++) begin
        d = rnd();
        wr_q.push_back({ptr + 8'(k), d});
        ref_m[ptr + 8'(k)] = d;
        cmd(4'h0, d, 3'h6);
      end
      // repeated start, read from the advanced pointer.
      cmd(4'h8, 8'h61, 3'h6);
      for (int k = 0; k < t + 2; k++) begin
        d = ref_m[ptr + 8'(t + k)];
        cmd((k == t + 1) ? 4'h7 : 4'h2, d, 3'h1);
      end
    end
    cmd(4'h8, 8'h62, 3'h4);
    cmd(4'h4, rnd(), 3'h4);
    // read from the pointer left behind.
    cmd(4'h8, 8'h61, 3'h6);
    cmd(4'h2, ref_m[ptr + 8'h06], 3'h1);
    cmd(4'h7, ref_m[ptr + 8'h07], 3'h1);
    for (int i = 0; i < 3000 && note_q.size() != 0; i++)
      @(posedge core_clk_i);
    repeat (50) @(posedge core_clk_i);
    if (note_q.size() != 0 || wr_q.size() != 0) mism("missing result");
    print_verdict();
  end
  initial begin
    repeat (40000) @(posedge core_clk_i);
    mism("timeout");
    print_verdict();
  end
endmodule
`default_nettype wire
